// *** pkg/fcl_pkg.sv ***
// Purpose: Constants for the fuse configuration loader
// Assumes: Fuse bytes are read one per cycle from a nonvolatile array port
// Notes: Offsets are fuse byte addresses; fields are bit positions
package fcl_pkg;
    // Fuse byte offsets
    localparam logic [3:0] WDT_OFS = 4'h0;
    localparam logic [3:0] BOD_OFS = 4'h1;
    localparam logic [3:0] OSC_OFS = 4'h2;
    localparam logic [3:0] SYS0_OFS = 4'h5;
    localparam logic [3:0] SYS1_OFS = 4'h6;
    localparam logic [3:0] APP_CODE_END_FUSE_OFS = 4'h7;
    localparam logic [3:0] BOOT_SECTION_END_FUSE_OFS = 4'h8;
    localparam logic [3:0] LOCK_OFS = 4'hA;
    localparam int NUM_FUSE = 8;
    // Field positions
    localparam int WIN_LSB = 4;
    localparam int PER_LSB = 0;
    localparam int LVL_LSB = 5;
    localparam int SAMP_BIT = 4;
    localparam int ACT_LSB = 2;
    localparam int SLP_LSB = 0;
    localparam int OSC_CAL_FREEZE_BIT = 7;
    localparam int FREQ_LSB = 0;
    localparam int CRC_LSB = 6;
    localparam int RSTPIN_BIT = 3;
    localparam int EEPROM_PRESERVE_ON_ERASE_BIT = 0;
    // Codes
    localparam logic [1:0] FREQ_16M = 2'h1;
    localparam logic [1:0] FREQ_20M = 2'h2;
    localparam logic [7:0] LOCK_OPEN_KEY = 8'hC5;
    // Factory-programmed values, never applied at reset
    localparam logic [7:0] FACT_WDT = 8'h00;
    localparam logic [7:0] FACT_BOD = 8'h00;
    localparam logic [7:0] FACT_OSC = 8'h02;
    localparam logic [7:0] FACT_SYS0 = 8'hE4;
    // Loader states, Gray along the path
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_CAL = 2'b11,
        ST_DONE = 2'b10
    } fcl_state_e;
endpackage : fcl_pkg

// *** rtl/fcl_rst_sync.sv ***
// Purpose: Two-flop reset release synchroniser
// Assumes: Active-low asynchronous assert
// Notes: Release lands two edges after rstIn_b rises
`timescale 1ns/1ns
module fcl_rst_sync (
    input wire logic clk,
    input wire logic rstIn_b,
    output logic rstOut_b
);
    logic stage1_q; // First flop, read only by second
    // Assert async, release through two flops
    always_ff @(posedge clk or negedge rstIn_b) begin
        if (!rstIn_b) begin
            stage1_q <= 1'b0;
            rstOut_b <= 1'b0;
        end else begin
            stage1_q <= 1'b1;
            rstOut_b <= stage1_q;
        end
    end
endmodule : fcl_rst_sync

// *** rtl/fcl_loader.sv ***
// Purpose: Copy fuse bytes into peripheral control fields at reset
// Assumes: Fuse array answers a read in the same cycle, while its strobe stands
// Notes: Targets stay in reset until every field has landed
//        Reserved frequency codes fall back to the 20 MHz set
//        A changed fuse only takes effect after the next reset
`timescale 1ns/1ns
module fcl_loader (
    input wire logic clk,
    input wire logic rst_b,
    output logic fuseRdEn,
    output logic [3:0] fuseAddr,
    input wire logic [7:0] fuseData,
    input wire logic [6:0] cal16Coarse,
    input wire logic [3:0] cal16Temp,
    input wire logic [6:0] cal20Coarse,
    input wire logic [3:0] cal20Temp,
    input wire logic chipEraseReq,
    output logic [3:0] wdtWindow,
    output logic [3:0] wdtPeriod,
    output logic [2:0] brownoutThresholdLevel,
    output logic brownoutSampleRate,
    output logic [1:0] bodActiveMode,
    output logic [1:0] bodSleepMode,
    output logic oscCalFreeze,
    output logic [1:0] rcOscFrequencySelect,
    output logic [6:0] rcOscCoarseCal,
    output logic [3:0] rcOscTempCal,
    output logic [1:0] flashCheckSource,
    output logic resetPinFunction,
    output logic eraseEeprom,
    output logic [7:0] appCodeEnd,
    output logic [7:0] bootSectionEnd,
    output logic [2:0] startUpTime,
    output logic deviceLocked,
    output logic targetRst_b,
    output logic loadDone
);
    // Everything below runs from the synchronised reset copy
    logic rstSync_b; // Synchronised reset copy
    fcl_rst_sync uRst (
        .clk(clk),
        .rstIn_b(rst_b),
        .rstOut_b(rstSync_b)
    );

    // Map load step to fuse offset
    // Offsets 0x03, 0x04 and 0x09 are skipped: they hold no field
    // Order matches the array so addresses climb monotonically
    function automatic logic [3:0] stepAddr(input logic [2:0] s);
        case (s)
            3'h0: stepAddr = fcl_pkg::WDT_OFS;
            3'h1: stepAddr = fcl_pkg::BOD_OFS;
            3'h2: stepAddr = fcl_pkg::OSC_OFS;
            3'h3: stepAddr = fcl_pkg::SYS0_OFS;
            3'h4: stepAddr = fcl_pkg::SYS1_OFS;
            3'h5: stepAddr = fcl_pkg::APP_CODE_END_FUSE_OFS;
            3'h6: stepAddr = fcl_pkg::BOOT_SECTION_END_FUSE_OFS;
            default: stepAddr = fcl_pkg::LOCK_OFS;
        endcase
    endfunction : stepAddr

    // Sequencer state and read bookkeeping
    fcl_pkg::fcl_state_e state_q, state_d;
    logic [2:0] step_q, step_d; // Index of fuse being read
    logic pend_q, pend_d; // Read issued, data due this cycle
    logic [2:0] pstep_q, pstep_d; // Step whose data is due
    // Capture storage and derived values
    logic [7:0] fuse_q [fcl_pkg::NUM_FUSE]; // Captured fuse bytes
    logic [7:0] fuse_d [fcl_pkg::NUM_FUSE];
    logic [6:0] coarse_q, coarse_d; // Chosen coarse calibration
    logic [3:0] temp_q, temp_d; // Chosen temperature calibration
    // Registered outputs
    logic rdEn_q, rdEn_d;
    logic [3:0] addr_q, addr_d;
    logic tgtRst_q, tgtRst_d;
    logic done_q, done_d;
    logic erase_q, erase_d;
    logic locked_q, locked_d; // Lock key invalid, registered for output

    // Sequencer: one fuse read per cycle, then calibration pick
    // The array answers from the registered address while the strobe
    // stands, so each byte is sampled on the edge that ends its strobe.
    // Reading in one burst keeps start-up short; targets see nothing
    // until the whole set has landed, so a half-loaded set never escapes.
    always_comb begin
        state_d = state_q;
        step_d = step_q;
        pend_d = 1'b0;
        pstep_d = pstep_q;
        fuse_d = fuse_q;
        coarse_d = coarse_q;
        temp_d = temp_q;
        rdEn_d = 1'b0;
        addr_d = addr_q;
        tgtRst_d = tgtRst_q;
        done_d = done_q;
        // Capture returning byte
        if (pend_q) begin
            fuse_d[pstep_q] = fuseData;
        end
        case (state_q)
            fcl_pkg::ST_IDLE: begin
                // One spare cycle after reset release before the first read
                state_d = fcl_pkg::ST_READ;
            end
            fcl_pkg::ST_READ: begin
                // Issue read for current step
                rdEn_d = 1'b1;
                addr_d = stepAddr(step_q);
                pend_d = 1'b1;
                pstep_d = step_q;
                if (step_q == 3'(fcl_pkg::NUM_FUSE - 1)) begin
                    state_d = fcl_pkg::ST_CAL;
                end else begin
                    step_d = step_q + 3'h1;
                end
            end
            fcl_pkg::ST_CAL: begin
                // Last byte lands now; oscillator byte already held
                case (fuse_q[2][fcl_pkg::FREQ_LSB +: 2])
                    fcl_pkg::FREQ_16M: begin
                        coarse_d = cal16Coarse;
                        temp_d = cal16Temp;
                    end
                    default: begin
                        // Reserved codes fall back to 20 MHz set
                        coarse_d = cal20Coarse;
                        temp_d = cal20Temp;
                    end
                endcase
                state_d = fcl_pkg::ST_DONE;
            end
            fcl_pkg::ST_DONE: begin
                // Release targets once all fields are in place
                // Held here until the next reset; no run-time reload
                tgtRst_d = 1'b1;
                done_d = 1'b1;
            end
            default: state_d = fcl_pkg::ST_IDLE;
        endcase
        // Lock flag rises on the same edge as loadDone
        locked_d = done_d &&
            (fuse_d[7] != fcl_pkg::LOCK_OPEN_KEY);
    end

    // Eraser policy, locked device always erases
    // A request before loadDone is ignored: the preserve bit and the
    // lock key are not yet known, and erasing on a guess loses data.
    // Locked parts must lose EEPROM whatever the preserve bit says.
    always_comb begin
        erase_d = 1'b0;
        if (chipEraseReq && done_q) begin
            erase_d = (fuse_q[7] != fcl_pkg::LOCK_OPEN_KEY) ||
                !fuse_q[3][fcl_pkg::EEPROM_PRESERVE_ON_ERASE_BIT];
        end
    end

    // Registers; reset takes constants only, not factory values
    // Zeros, not factory values, keep a half-read set visibly blank
    // rather than a plausible configuration.
    // The async reset is the synchronised copy, so release is clean.
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            state_q <= fcl_pkg::ST_IDLE;
            step_q <= 3'h0;
            pend_q <= 1'b0;
            pstep_q <= 3'h0;
            for (int i = 0; i < fcl_pkg::NUM_FUSE; i++) begin
                fuse_q[i] <= 8'h00;
            end
            coarse_q <= 7'h00;
            temp_q <= 4'h0;
            rdEn_q <= 1'b0;
            addr_q <= 4'h0;
            tgtRst_q <= 1'b0;
            done_q <= 1'b0;
            erase_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            pend_q <= pend_d;
            pstep_q <= pstep_d;
            fuse_q <= fuse_d;
            coarse_q <= coarse_d;
            temp_q <= temp_d;
            rdEn_q <= rdEn_d;
            addr_q <= addr_d;
            tgtRst_q <= tgtRst_d;
            done_q <= done_d;
            erase_q <= erase_d;
            locked_q <= locked_d;
        end
    end

    // Field outputs straight from captured flops
    // Each field is a plain slice of a capture flop, so no logic sits
    // between the flop and the target block's control input.
    assign fuseRdEn = rdEn_q;
    assign fuseAddr = addr_q;
    assign wdtWindow = fuse_q[0][fcl_pkg::WIN_LSB +: 4];
    assign wdtPeriod = fuse_q[0][fcl_pkg::PER_LSB +: 4];
    assign brownoutThresholdLevel = fuse_q[1][fcl_pkg::LVL_LSB +: 3];
    assign brownoutSampleRate = fuse_q[1][fcl_pkg::SAMP_BIT];
    assign bodActiveMode = fuse_q[1][fcl_pkg::ACT_LSB +: 2];
    assign bodSleepMode = fuse_q[1][fcl_pkg::SLP_LSB +: 2];
    assign oscCalFreeze = fuse_q[2][fcl_pkg::OSC_CAL_FREEZE_BIT];
    assign rcOscFrequencySelect = fuse_q[2][fcl_pkg::FREQ_LSB +: 2];
    assign rcOscCoarseCal = coarse_q;
    assign rcOscTempCal = temp_q;
    assign flashCheckSource = fuse_q[3][fcl_pkg::CRC_LSB +: 2];
    assign resetPinFunction = fuse_q[3][fcl_pkg::RSTPIN_BIT];
    assign startUpTime = fuse_q[4][2:0];
    assign appCodeEnd = fuse_q[5];
    assign bootSectionEnd = fuse_q[6];
    assign deviceLocked = locked_q;
    assign eraseEeprom = erase_q;
    assign targetRst_b = tgtRst_q;
    assign loadDone = done_q;

    // Checks
    // Each load assertion looks one edge after the byte is sampled, so
    // it sees the field flop, not the array's answer.
    // Watchdog byte fields
    wdt_load_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        (pend_q && pstep_q == 3'h0) |=> wdtWindow == $past(fuseData[7:4])
            && wdtPeriod == $past(fuseData[3:0]))
        else $error("watchdog fields not loaded");
    // Brown-out byte fields
    bod_load_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        (pend_q && pstep_q == 3'h1) |=> {brownoutThresholdLevel,
            brownoutSampleRate, bodActiveMode, bodSleepMode}
            == $past(fuseData))
        else $error("brownout fields not loaded");
    // 16 MHz code takes the 16 MHz coarse calibration value
    cal_pick_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        $rose(loadDone) && rcOscFrequencySelect == fcl_pkg::FREQ_16M
            |-> rcOscCoarseCal == $past(cal16Coarse, 2))
        else $error("16 MHz calibration not chosen");
    // Targets stay in reset until the sequencer is done
    tgt_hold_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        targetRst_b |-> state_q == fcl_pkg::ST_DONE)
        else $error("targets released early");
    // Release comes within 10 to 12 edges after reset release
    rel_time_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        $rose(rstSync_b) ##0 1'b1 |-> ##[10:12] targetRst_b)
        else $error("targets not released in time");
    // Locked part always erases
    ee_erase_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        (chipEraseReq && loadDone && deviceLocked) |=> eraseEeprom)
        else $error("locked erase kept eeprom");
    // Open part with preserve set keeps EEPROM
    ee_keep_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        (chipEraseReq && loadDone && !deviceLocked
            && fuse_q[3][fcl_pkg::EEPROM_PRESERVE_ON_ERASE_BIT]) |=> !eraseEeprom)
        else $error("eeprom erased despite preserve");
    // Fields frozen once loading ends
    stable_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        loadDone |=> $stable(wdtWindow) && $stable(flashCheckSource)
            && $stable(resetPinFunction) && $stable(oscCalFreeze))
        else $error("fields changed after load");
    // Oscillator byte fields
    osc_load_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        (pend_q && pstep_q == 3'h2) |=> oscCalFreeze == $past(fuseData[7])
            && rcOscFrequencySelect == $past(fuseData[1:0]))
        else $error("oscillator fields not loaded");
    // System byte zero fields
    sys_load_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        (pend_q && pstep_q == 3'h3) |=> flashCheckSource
            == $past(fuseData[7:6])
            && resetPinFunction == $past(fuseData[3]))
        else $error("system fields not loaded");
    // Other frequency codes take the 20 MHz set
    cal20_pick_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        $rose(loadDone) && rcOscFrequencySelect != fcl_pkg::FREQ_16M
            |-> rcOscCoarseCal == $past(cal20Coarse, 2)
            && rcOscTempCal == $past(cal20Temp, 2))
        else $error("20 MHz calibration not chosen");
    // No erase decision before the fuse set is complete
    erase_early_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        !loadDone |-> !eraseEeprom)
        else $error("erase decided before load");
    // Lock output follows the key byte once loading ends
    lock_flag_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        loadDone |-> deviceLocked
            == (fuse_q[7] != fcl_pkg::LOCK_OPEN_KEY))
        else $error("lock flag wrong");
    // Reads stop once the last byte is in
    read_stop_a: assert property (@(posedge clk) disable iff (!rstSync_b)
        loadDone |-> !fuseRdEn)
        else $error("fuse read after load");
    // Main scenarios: load, locked erase, 16 MHz pick, kept EEPROM
    load_c: cover property (@(posedge clk) $rose(loadDone));
    keep_c: cover property (@(posedge clk)
        loadDone && chipEraseReq && !deviceLocked && !eraseEeprom);
    lock_c: cover property (@(posedge clk) eraseEeprom && deviceLocked);
    f16_c: cover property (@(posedge clk)
        loadDone && rcOscFrequencySelect == fcl_pkg::FREQ_16M);
endmodule : fcl_loader

// *** tb/fcl_fuse_model.sv ***
// Purpose: Nonvolatile fuse array seen by the loader's read port
// Assumes: Byte answered from the address while the read strobe stands
// Notes: Reserved bits are forced to one as any fuse writer must
`timescale 1ns/1ns
module fcl_fuse_model (
    input wire logic clk,
    input wire logic fuseRdEn,
    input wire logic [3:0] fuseAddr,
    output logic [7:0] fuseData
);
    // Fuse bytes, unwritten places read as erased ones
    logic [7:0] mem [0:15];
    logic [7:0] junk = 8'h00; // Filler shown while no read is open
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end

    // Store a fuse value with its reserved positions set
    task automatic setFuse(input logic [3:0] a, input logic [7:0] v);
        case (a)
            4'h2: mem[a] = v | 8'h7C;
            4'h5: mem[a] = v | 8'h36;
            4'h6: mem[a] = v | 8'hF8;
            default: mem[a] = v;
        endcase
    endtask : setFuse

    // Answer a read while its strobe stands; otherwise toggling filler
    // so stale data never looks valid
    always @(posedge clk) begin
        junk <= ~junk;
    end
    assign fuseData = (fuseRdEn === 1'b1) ? mem[fuseAddr] : junk;
endmodule : fcl_fuse_model

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the fuse configuration loader
// Assumes: Fuse model answers reads; calibration inputs static
// Notes: Each load is a fresh reset, expectations from field slices
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic chipEraseReq = 1'b0;
    logic [7:0] fuseData, appCodeEnd, bootSectionEnd;
    logic [6:0] rcOscCoarseCal;
    logic [3:0] fuseAddr, wdtWindow, wdtPeriod, rcOscTempCal;
    logic [2:0] brownoutThresholdLevel, startUpTime;
    logic [1:0] bodActiveMode, bodSleepMode;
    logic [1:0] rcOscFrequencySelect, flashCheckSource;
    logic fuseRdEn, brownoutSampleRate, oscCalFreeze, resetPinFunction;
    logic eraseEeprom, deviceLocked, targetRst_b, loadDone;
    int nErrors = 0;
    int testsRun = 0;
    // Addresses seen on the read port, in order
    logic [3:0] rdQ [$];
    localparam logic [3:0] OFS [8] = '{4'h0, 4'h1, 4'h2, 4'h5,
                                      4'h6, 4'h7, 4'h8, 4'hA};

    // 25 MHz clock
    always #20 clk = ~clk;

    // Log every read strobe with its address
    always @(posedge clk) begin
        if (fuseRdEn === 1'b1) begin
            rdQ.push_back(fuseAddr);
        end
    end

    fcl_fuse_model fcl_fuse_model_inst (.clk(clk), .fuseRdEn(fuseRdEn),
        .fuseAddr(fuseAddr), .fuseData(fuseData));

    // Calibration sets tied to distinct values so a wrong pick shows
    fcl_loader fcl_loader_inst (.clk(clk), .rst_b(rst_b),
        .fuseRdEn(fuseRdEn), .fuseAddr(fuseAddr), .fuseData(fuseData),
        .cal16Coarse(7'h2A), .cal16Temp(4'h5), .cal20Coarse(7'h55),
        .cal20Temp(4'hA), .chipEraseReq(chipEraseReq),
        .wdtWindow(wdtWindow), .wdtPeriod(wdtPeriod),
        .brownoutThresholdLevel(brownoutThresholdLevel),
        .brownoutSampleRate(brownoutSampleRate),
        .bodActiveMode(bodActiveMode), .bodSleepMode(bodSleepMode),
        .oscCalFreeze(oscCalFreeze),
        .rcOscFrequencySelect(rcOscFrequencySelect),
        .rcOscCoarseCal(rcOscCoarseCal), .rcOscTempCal(rcOscTempCal),
        .flashCheckSource(flashCheckSource),
        .resetPinFunction(resetPinFunction), .eraseEeprom(eraseEeprom),
        .appCodeEnd(appCodeEnd), .bootSectionEnd(bootSectionEnd),
        .startUpTime(startUpTime), .deviceLocked(deviceLocked),
        .targetRst_b(targetRst_b), .loadDone(loadDone));

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic conclude();
        $display("Errors %0d in %0d checks", nErrors, testsRun);
        if (nErrors == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // Program fuses, reset, load, then judge every field
    task automatic runLoad(input logic [7:0] w, b, o, s0, s1, ap, bt, lk);
        int k;
        logic is16;
        is16 = (o[1:0] == 2'h1);
        fcl_fuse_model_inst.setFuse(4'h0, w);
        fcl_fuse_model_inst.setFuse(4'h1, b);
        fcl_fuse_model_inst.setFuse(4'h2, o);
        fcl_fuse_model_inst.setFuse(4'h5, s0);
        fcl_fuse_model_inst.setFuse(4'h6, s1);
        fcl_fuse_model_inst.setFuse(4'h7, ap);
        fcl_fuse_model_inst.setFuse(4'h8, bt);
        fcl_fuse_model_inst.setFuse(4'hA, lk);
        rst_b = 1'b0;
        chipEraseReq = 1'b1;
        @(posedge clk);
        #1;
        rdQ.delete();
        check(8'(rcOscFrequencySelect), 8'h00);
        check(8'(flashCheckSource), 8'h00);
        rst_b = 1'b1;
        // Targets held and erase ignored until loading ends
        for (k = 0; k < 40 && loadDone !== 1'b1; k++) begin
            check(8'(targetRst_b), 8'h00);
            check(8'(eraseEeprom), 8'h00);
            @(posedge clk);
            #1;
        end
        if (loadDone !== 1'b1) begin
            nErrors++;
            conclude();
        end
        check(8'(targetRst_b), 8'h01);
        check(8'(rdQ.size()), 8'h08);
        for (k = 0; k < 8 && k < rdQ.size(); k++) begin
            check(8'(rdQ[k]), 8'(OFS[k]));
        end
        check(8'(wdtWindow), 8'(w[7:4]));
        check(8'(wdtPeriod), 8'(w[3:0]));
        check(8'(brownoutThresholdLevel), 8'(b[7:5]));
        check(8'(brownoutSampleRate), 8'(b[4]));
        check(8'(bodActiveMode), 8'(b[3:2]));
        check(8'(bodSleepMode), 8'(b[1:0]));
        check(8'(oscCalFreeze), 8'(o[7]));
        check(8'(rcOscFrequencySelect), 8'(o[1:0]));
        check(8'(rcOscCoarseCal), is16 ? 8'h2A : 8'h55);
        check(8'(rcOscTempCal), is16 ? 8'h05 : 8'h0A);
        check(8'(flashCheckSource), 8'(s0[7:6]));
        check(8'(resetPinFunction), 8'(s0[3]));
        check(8'(startUpTime), 8'(s1[2:0]));
        check(appCodeEnd, ap);
        check(bootSectionEnd, bt);
        check(8'(deviceLocked), 8'(lk != 8'hC5));
        @(posedge clk);
        #1;
        check(8'(eraseEeprom), 8'((lk != 8'hC5) || !s0[0]));
        chipEraseReq = 1'b0;
        @(posedge clk);
        #1;
        check(8'(eraseEeprom), 8'h00);
    endtask : runLoad

    // A fuse change without reset must not reach the targets
    task automatic noReload();
        fcl_fuse_model_inst.setFuse(4'h0, 8'h5A);
        repeat (20) @(posedge clk);
        #1;
        check(8'(wdtWindow), 8'h0A);
        check(8'(rdQ.size()), 8'h08);
    endtask : noReload

    initial begin
        repeat (20) @(posedge clk);
        #1;
        runLoad(8'hA5, 8'hE9, 8'h81, 8'h09, 8'h05, 8'h12, 8'h04, 8'hC5);
        noReload();
        runLoad(8'h3C, 8'h5E, 8'h80, 8'hB6, 8'h00, 8'hFF, 8'h80, 8'hC5);
        runLoad(8'hF0, 8'h07, 8'h03, 8'h41, 8'h07, 8'h00, 8'h00, 8'h00);
        runLoad(8'h00, 8'h00, 8'h02, 8'hE4, 8'h07, 8'h00, 8'h00, 8'hC5);
        conclude();
    end
endmodule : tb
